// >>> dv/ahbwp_host.sv
// behavioural host processor driving the port pins
`timescale 1ns/1ps
module ahbwp_host (
  input wire logic sys_clk_i,
  input wire logic xfer_ready_n_i,
  input wire logic [7:0] data_i,
  output logic [14:0] addr_o,
  output logic chip_sel_n_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_o,
  output logic [7:0] data_o
);
  // ----------------------------------------
  // bus cycles, driven at the falling edge
  // ----------------------------------------
  task automatic idle(input bit ds);
    chip_sel_n_o = 1'b1;
    addr_o = 15'h7fff;
    ale_o = ds;
    rd_n_o = 1'b1;
    wr_o = 1'b1;
    data_o = 8'h5a;
  endtask
  task automatic xfer(input bit ds, input bit rd, input bit cs_n, input logic [14:0] a,
                      input logic [7:0] wd, output logic [7:0] q, output bit ok);
    @(negedge sys_clk_i);
    addr_o = a;
    chip_sel_n_o = cs_n;
    ale_o = !ds;
    wr_o = ds ? rd : 1'b1;
    repeat (3) @(negedge sys_clk_i);
    ale_o = ds;
    @(negedge sys_clk_i);
    // address bus wanders after the latch closes, as a real host's would
    addr_o = ~a;
    data_o = rd ? ~wd : wd;
    repeat (3) @(negedge sys_clk_i);
    if (ds || rd) rd_n_o = 1'b0;
    else wr_o = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge sys_clk_i);
      ok = !xfer_ready_n_i;
      q = data_i;
    end
    @(negedge sys_clk_i);
    rd_n_o = 1'b1;
    wr_o = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    chip_sel_n_o = 1'b1;
    data_o = ~data_o;
  endtask
endmodule

// >>> dv/ahbwp_port_properties.sv
// pin-level checks for the host bus port
`timescale 1ns/1ps
module ahbwp_port_properties (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] host_bus_type_sel_i,
  input wire logic chip_sel_n_i,
  input wire logic read_or_data_strobe_n_i,
  input wire logic write_n_or_rw_sel_i,
  input wire logic data_oe_o,
  input wire logic xfer_ready_n_o,
  input wire logic ds_mode_o
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic sep;
  logic dsm;
  logic [3:0] idle_r;
  assign sep = host_bus_type_sel_i == 3'h0 && !chip_sel_n_i;
  assign dsm = host_bus_type_sel_i == 3'h1 && !chip_sel_n_i;
  // counts quiet cycles; the rw select line is only a strobe outside data-strobe mode
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) idle_r <= 4'h0;
    else if (!read_or_data_strobe_n_i || (!write_n_or_rw_sel_i && !ds_mode_o)) idle_r <= 4'h0;
    else if (idle_r != 4'hf) idle_r <= idle_r + 4'h1;
  end
  wr_not_ready_a:
    assert property (sep && $fell(write_n_or_rw_sel_i) |-> xfer_ready_n_o [*3])
    else $error("ready low too early after write strobe");
  wr_ready_a:
    assert property (sep && $fell(write_n_or_rw_sel_i) |-> ##[4:12] !xfer_ready_n_o)
    else $error("no ready after write strobe");
  wr_release_a:
    assert property (sep && $rose(write_n_or_rw_sel_i) && !xfer_ready_n_o
      |-> ##[1:6] xfer_ready_n_o)
    else $error("ready not released after write strobe");
  quiet_bus_a:
    assert property (idle_r == 4'hf |-> xfer_ready_n_o && !data_oe_o)
    else $error("port active with strobes idle");
  cs_ignore_a:
    assert property (chip_sel_n_i [*8] |-> xfer_ready_n_o)
    else $error("ready given without chip select");
  rd_drive_a:
    assert property (sep && $fell(read_or_data_strobe_n_i) |-> ##[2:5] data_oe_o)
    else $error("read data not driven");
  wr_no_drive_a:
    assert property (sep && $fell(write_n_or_rw_sel_i) |-> !data_oe_o [*8])
    else $error("data driven during write");
  mode_sep_a:
    assert property (host_bus_type_sel_i == 3'h0 [*6] |-> !ds_mode_o)
    else $error("wrong mode for all-low strap");
  mode_ds_a:
    assert property (host_bus_type_sel_i == 3'h1 [*6] |-> ds_mode_o)
    else $error("data-strobe mode not selected");
  ds_ack_a:
    assert property (dsm && $fell(read_or_data_strobe_n_i)
      |-> xfer_ready_n_o [*3] ##[1:10] !xfer_ready_n_o)
    else $error("acknowledge timing wrong");
  ds_dir_a:
    assert property (dsm && $fell(read_or_data_strobe_n_i) && write_n_or_rw_sel_i
      |-> ##[2:5] data_oe_o)
    else $error("data-strobe read not driven");
  cover property (sep && $fell(write_n_or_rw_sel_i));
  cover property (sep && $fell(read_or_data_strobe_n_i));
  cover property (dsm && $fell(read_or_data_strobe_n_i));
endmodule

// >>> dv/async_host_bus_write_port_bench.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
module async_host_bus_write_port_bench;
  import ahbwp_pkg::*;
  logic sys_clk_i;
  logic rst_i;
  logic [2:0] sel;
  logic [14:0] addr;
  logic cs_n, ale, rds, wrs, oe, rdy_n, dsm;
  logic [7:0] hdat, dout, q;
  bit ok;
  int miscompares, compares, cycles;
  ahbwp_host u_host (.sys_clk_i(sys_clk_i), .xfer_ready_n_i(rdy_n), .data_i(dout),
    .addr_o(addr), .chip_sel_n_o(cs_n), .ale_o(ale), .rd_n_o(rds), .wr_o(wrs), .data_o(hdat));
  ahbwp_port u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .host_bus_type_sel_i(sel),
    .addr_i(addr), .chip_sel_n_i(cs_n), .addr_latch_strobe_i(ale),
    .read_or_data_strobe_n_i(rds), .write_n_or_rw_sel_i(wrs), .data_i(hdat), .data_o(dout),
    .data_oe_o(oe), .xfer_ready_n_o(rdy_n), .ds_mode_o(dsm));
  // ----------------------------------------
  // checking and control
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] mode);
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    sel = mode;
    u_host.idle(mode == 3'h1);
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
  endtask
  // same index in every region, so aliasing between regions shows up
  task automatic t_sep_regions();
    do_reset(BUS_TYPE_SEP);
    chk1(dsm, 1'b0);
    for (int r = 0; r < 4; r++) u_host.xfer(0, 0, 0, {r[1:0], 7'h2a, 6'h3f}, 8'ha0 + 8'(r), q, ok);
    for (int r = 0; r < 4; r++) begin
      u_host.xfer(0, 1, 0, {r[1:0], 7'h2a, 6'h3f}, 8'h00, q, ok);
      chk1(ok, 1'b1);
      chk8(q, 8'ha0 + 8'(r));
    end
  endtask
  task automatic t_sep_b2b_and_cs();
    u_host.xfer(0, 0, 0, 15'h0000, 8'h11, q, ok);
    u_host.xfer(0, 0, 0, 15'h0000, 8'hee, q, ok);
    u_host.xfer(0, 0, 1, 15'h0000, 8'h77, q, ok);
    chk1(ok, 1'b0);
    u_host.xfer(0, 1, 0, 15'h0000, 8'h00, q, ok);
    chk8(q, 8'hee);
  endtask
  task automatic t_ds();
    do_reset(BUS_TYPE_DS);
    chk1(dsm, 1'b1);
    u_host.xfer(1, 0, 0, 15'h2005, 8'h3c, q, ok);
    chk1(ok, 1'b1);
    u_host.xfer(1, 0, 0, 15'h6005, 8'hc3, q, ok);
    u_host.xfer(1, 1, 0, 15'h2005, 8'h00, q, ok);
    chk8(q, 8'h3c);
    u_host.xfer(1, 1, 0, 15'h6005, 8'h00, q, ok);
    chk8(q, 8'hc3);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rst_i = 1'b1;
    sel = BUS_TYPE_SEP;
    u_host.idle(0);
    t_sep_regions();
    t_sep_b2b_and_cs();
    t_ds();
    summarize();
  end
endmodule
bind ahbwp_port ahbwp_port_properties u_props (.sys_clk_i, .rst_i, .host_bus_type_sel_i,
  .chip_sel_n_i, .read_or_data_strobe_n_i, .write_n_or_rw_sel_i, .data_oe_o, .xfer_ready_n_o,
  .ds_mode_o);

// >>> src/ahbwp_pkg.sv
// constants and types for the asynchronous host bus write port
// What this block does
// - separate-strobe: address latch strobe high passes the address through
// - separate-strobe: address captured and held on latch strobe falling edge
// - write strobe low enables data input toward the latched location
// - ready stays high after write strobe falls; host holds strobe low
// - ready driven low once write data can be safely accepted
// - byte on the data bus stored at write strobe rising edge
// - writes reach control registers and the three message/cell memories
// - data-strobe: latch pin is active-low, address captured on rising edge
// - data-strobe: read strobe pin is the active-low data strobe
// - data-strobe: ready pin acts as active-low transfer acknowledge
// - data-strobe: read/write select sampled at data strobe fall, high is read
// - all bus-type selects low picks separate-strobe mode
// - upper selects low, lowest high picks data-strobe mode
// - separate-strobe read drives data while read strobe low, else tri-state
package ahbwp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int TYPE_W = 3;
  localparam logic [2:0] BUS_TYPE_SEP = 3'h0;
  localparam logic [2:0] BUS_TYPE_DS = 3'h1;
  // internal access time before ready/acknowledge is given
  localparam int ACCESS_NS = 80;
  localparam int CLK_NS = 40;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  // location map: four regions chosen by the top address bits
  localparam int REGION_LSB = 13;
  localparam logic [1:0] REGION_CTRL = 2'h0;
  localparam logic [1:0] REGION_TX_MSG = 2'h1;
  localparam logic [1:0] REGION_TX_CELL = 2'h2;
  localparam logic [1:0] REGION_RX_CELL = 2'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_READY,
    ST_RELEASE
  } ahbwp_state_e;
endpackage

// >>> src/ahbwp_port.sv
// asynchronous host bus port: strobes, address latch, ready and storage
`timescale 1ns/1ps
module ahbwp_port #(
  parameter int IDX_W = 6,
  parameter int ACC_CYCLES = ahbwp_pkg::ACCESS_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ahbwp_pkg::TYPE_W-1:0] host_bus_type_sel_i,
  input wire logic [ahbwp_pkg::ADDR_W-1:0] addr_i,
  input wire logic chip_sel_n_i,
  input wire logic addr_latch_strobe_i,
  input wire logic read_or_data_strobe_n_i,
  input wire logic write_n_or_rw_sel_i,
  input wire logic [ahbwp_pkg::DATA_W-1:0] data_i,
  output logic [ahbwp_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic xfer_ready_n_o,
  output logic ds_mode_o
);
  import ahbwp_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_n_sync_r;
  logic [1:0] ale_sync_r;
  logic [1:0] rd_sync_r;
  logic [1:0] wr_sync_r;
  logic [TYPE_W-1:0] type_s1_r;
  logic [TYPE_W-1:0] type_s2_r;
  logic [ADDR_W-1:0] addr_s1_r;
  logic [ADDR_W-1:0] addr_s2_r;
  logic [DATA_W-1:0] data_s1_r;
  logic [DATA_W-1:0] data_s2_r;

  // all host pins are asynchronous to sys_clk_i
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_n_sync_r <= 2'h3;
      ale_sync_r <= 2'h0;
      rd_sync_r <= 2'h3;
      wr_sync_r <= 2'h3;
      type_s1_r <= '0;
      type_s2_r <= '0;
      addr_s1_r <= '0;
      addr_s2_r <= '0;
      data_s1_r <= '0;
      data_s2_r <= '0;
    end else begin
      cs_n_sync_r <= {cs_n_sync_r[0], chip_sel_n_i};
      ale_sync_r <= {ale_sync_r[0], addr_latch_strobe_i};
      rd_sync_r <= {rd_sync_r[0], read_or_data_strobe_n_i};
      wr_sync_r <= {wr_sync_r[0], write_n_or_rw_sel_i};
      type_s1_r <= host_bus_type_sel_i;
      type_s2_r <= type_s1_r;
      addr_s1_r <= addr_i;
      addr_s2_r <= addr_s1_r;
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // mode select and delayed copies for edge detection
  // ----------------------------------------------------------------
  logic cs_q_r;
  logic ale_q_r;
  logic rd_q_r;
  logic wr_q_r;
  logic ds_mode_r;
  logic sep_mode_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_q_r <= 1'b1;
      ale_q_r <= 1'b0;
      rd_q_r <= 1'b1;
      wr_q_r <= 1'b1;
      ds_mode_r <= 1'b0;
      sep_mode_r <= 1'b1;
    end else begin
      cs_q_r <= cs_n_sync_r[1];
      ale_q_r <= ale_sync_r[1];
      rd_q_r <= rd_sync_r[1];
      wr_q_r <= wr_sync_r[1];
      sep_mode_r <= (type_s2_r == BUS_TYPE_SEP);
      ds_mode_r <= (type_s2_r == BUS_TYPE_DS);
    end
  end

  wire cs_act = ~cs_n_sync_r[1];
  wire ale_s = ale_sync_r[1];
  wire rd_s = rd_sync_r[1];
  wire wr_s = wr_sync_r[1];
  // separate strobe: latch open while high, closes on fall
  wire sep_ale_open = sep_mode_r & ale_s;
  wire sep_ale_close = sep_mode_r & ale_q_r & ~ale_s;
  // data strobe: latch open while low, closes on rise
  wire ds_ale_open = ds_mode_r & ~ale_s;
  wire ds_ale_close = ds_mode_r & ~ale_q_r & ale_s;
  wire addr_open = cs_act & (sep_ale_open | ds_ale_open);
  wire addr_close = cs_act & (sep_ale_close | ds_ale_close);
  // the data strobe times every transfer in data-strobe mode
  wire ds_fall = ds_mode_r & cs_act & rd_q_r & ~rd_s;
  wire ds_rise = ds_mode_r & ~rd_q_r & rd_s;
  wire sep_wr_fall = sep_mode_r & cs_act & wr_q_r & ~wr_s;
  wire sep_wr_rise = sep_mode_r & ~wr_q_r & wr_s;
  wire sep_rd_fall = sep_mode_r & cs_act & rd_q_r & ~rd_s;
  wire sep_rd_rise = sep_mode_r & ~rd_q_r & rd_s;
  // high selects read, low selects write, taken at the strobe fall
  wire ds_is_read = wr_s;
  wire start_wr = sep_wr_fall | (ds_fall & ~ds_is_read);
  wire start_rd = sep_rd_fall | (ds_fall & ds_is_read);
  wire strobe_end = sep_wr_rise | sep_rd_rise | ds_rise;

  // ----------------------------------------------------------------
  // address latch
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_lat_r;
  logic [ADDR_W-1:0] addr_lat_nxt;
  assign addr_lat_nxt = (addr_open | addr_close) ? addr_s2_r : addr_lat_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_lat_r <= '0;
    end else begin
      addr_lat_r <= addr_lat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  ahbwp_state_e state_r;
  ahbwp_state_e state_nxt;
  logic is_wr_r;
  logic is_wr_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic rdy_n_r;
  logic rdy_n_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [DATA_W-1:0] wr_byte_r;
  logic commit_r;
  logic [DATA_W-1:0] rd_byte;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rdy_n_nxt = rdy_n_r;
    case (state_r)
      ST_IDLE: begin
        rdy_n_nxt = 1'b1;
        if (start_wr | start_rd) begin
          state_nxt = ST_ACCESS;
          cnt_nxt = CNT_W'(ACC_CYCLES);
        end
      end
      ST_ACCESS: begin
        // not ready while the internal access runs
        rdy_n_nxt = 1'b1;
        if (strobe_end) begin
          state_nxt = ST_IDLE;
        end else if (cnt_r <= CNT_W'(1)) begin
          state_nxt = ST_READY;
          rdy_n_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end
      end
      ST_READY: begin
        if (strobe_end) begin
          state_nxt = ST_RELEASE;
          rdy_n_nxt = 1'b1;
        end
      end
      ST_RELEASE: begin
        rdy_n_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        rdy_n_nxt = 1'b1;
      end
    endcase
  end

  // direction of the transfer about to start, not the last one, so a write
  // that follows a read never drives the bus for a cycle
  assign is_wr_nxt = (start_wr | start_rd) ? start_wr : is_wr_r;
  // read data drives only while the strobe is low and a read is open
  assign oe_nxt = ~is_wr_nxt & (state_nxt == ST_ACCESS || state_nxt == ST_READY);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      rdy_n_r <= 1'b1;
      is_wr_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rdy_n_r <= rdy_n_nxt;
      oe_r <= oe_nxt;
      is_wr_r <= is_wr_nxt;
    end
  end

  // data is followed while the write strobe is low, stored at its rise
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_byte_r <= '0;
      commit_r <= 1'b0;
    end else begin
      if (is_wr_r && (state_r == ST_ACCESS || state_r == ST_READY)) begin
        wr_byte_r <= data_s2_r;
      end
      // a write cut short before ready is dropped
      commit_r <= is_wr_r & (state_r == ST_READY) & strobe_end;
    end
  end

  ahbwp_store #(
    .AW(IDX_W),
    .DEPTH(1 << IDX_W)
  ) u_store (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(commit_r),
    .wr_region_i(addr_lat_r[REGION_LSB +: 2]),
    .rd_region_i(addr_lat_r[REGION_LSB +: 2]),
    .wr_index_i(addr_lat_r[IDX_W-1:0]),
    .rd_index_i(addr_lat_r[IDX_W-1:0]),
    .wr_data_i(wr_byte_r),
    .rd_data_o(rd_byte)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= '0;
      data_oe_o <= 1'b0;
      xfer_ready_n_o <= 1'b1;
      ds_mode_o <= 1'b0;
    end else begin
      data_o <= rd_byte;
      data_oe_o <= oe_r;
      xfer_ready_n_o <= rdy_n_r;
      ds_mode_o <= ds_mode_r;
    end
  end
endmodule

// >>> src/ahbwp_store.sv
// byte storage for control registers and message/cell memories
`timescale 1ns/1ps
module ahbwp_store #(
  parameter int AW = 6,
  parameter int DEPTH = 64
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_region_i,
  input wire logic [1:0] rd_region_i,
  input wire logic [AW-1:0] wr_index_i,
  input wire logic [AW-1:0] rd_index_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o
);
  import ahbwp_pkg::*;
  logic [7:0] mem_r [4][DEPTH];
  // every region takes byte writes alike
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int r = 0; r < 4; r++) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_r[r][i] <= RESET_BYTE;
        end
      end
    end else if (wr_en_i) begin
      mem_r[wr_region_i][wr_index_i] <= wr_data_i;
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= RESET_BYTE;
    end else begin
      rd_data_o <= mem_r[rd_region_i][rd_index_i];
    end
  end
endmodule
